// File: shared/fcs_pkg.sv
package fcs_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h60;
    localparam logic [7:0] OFS_CMD = 8'h64;
    localparam logic [7:0] OFS_STAT = 8'h68;
    // command word layout
    localparam int KEY_HI = 31;
    localparam int KEY_LO = 24;
    localparam int PAGE_HI = 17;
    localparam int PAGE_LO = 8;
    localparam int CODE_HI = 3;
    localparam int CODE_LO = 0;
    localparam logic [7:0] CMD_KEY = 8'h5a;
    localparam int PAGE_FIELD_W = PAGE_HI - PAGE_LO + 1;
    // command codes
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WRITE_PAGE = 4'h1;
    localparam logic [3:0] CMD_SET_LOCK = 4'h2;
    localparam logic [3:0] CMD_WRITE_PAGE_LOCK = 4'h3;
    localparam logic [3:0] CMD_UNLOCK_REGION = 4'h4;
    localparam logic [3:0] CMD_ERASE_ALL = 4'h8;
    localparam logic [3:0] CMD_SET_USER_NVM_BIT = 4'hb;
    localparam logic [3:0] CMD_CLEAR_USER_NVM_BIT = 4'hd;
    localparam logic [3:0] CMD_SET_SECURITY = 4'hf;
    // status bit positions
    localparam int ST_BIT_IDLE = 0;
    localparam int ST_BIT_LOCK_ERR = 2;
    localparam int ST_BIT_BAD_CMD = 3;
    localparam int ST_BIT_SECURITY = 4;
    localparam int ST_BIT_NVM = 8;
    localparam int ST_BIT_LOCKS = 16;
    // mode register bit positions
    localparam int MD_BIT_IE_IDLE = 0;
    localparam int MD_BIT_IE_LOCK = 2;
    localparam int MD_BIT_IE_BAD = 3;
    localparam int MD_BIT_SKIP_ERASE = 7;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] MODE_MASK = 32'h0000_008d;
    // configuration defaults
    localparam int REGIONS_MAX = 16;
    localparam int NVM_BITS = 2;
    // operation lengths in core clock cycles
    localparam logic [15:0] PAGE_ERASE_CYC = 16'h0040;
    localparam logic [15:0] PAGE_PROG_CYC = 16'h0080;
    localparam logic [15:0] FULL_ERASE_CYC = 16'h0100;
    localparam logic [15:0] NVM_WRITE_CYC = 16'h0020;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ERASE = 5'b00010,
        ST_PROG = 5'b00100,
        ST_LOCK = 5'b01000,
        ST_NVM = 5'b10000
    } fcs_state_t;
endpackage : fcs_pkg

// File: src/fcs_flash_command_status_unit.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
// Operation
// R1: code zero does nothing and leaves the bad command flag alone.
// R2: code write_page programs the page given by page_index.
// R3: code set_lock locks the region holding the selected page.
// R4: write_page_lock programs the page, then locks its region.
// R5: code unlock_region unlocks the region holding the selected page.
// R6: code erase_all erases the whole array.
// R7: erase_all is cancelled while any region is locked.
// R8: set_user_nvm_bit activates the user bit numbered by page_index.
// R9: clear_user_nvm_bit deactivates the user bit numbered by page_index.
// R10: set_security sets the security bit; page_index ignored.
// R11: reserved codes set bad_command_error and start nothing.
// R12: page_index is bits 17..8; page or bit number by command.
// R13: page_index bits beyond what a command needs are ignored.
// R14: key byte must be 0x5a, else the write is discarded.
// R15: wrong key or invalid code sets bad_command_error, status bit 3.
// R16: flash_idle, status bit 0, is 0 while busy, 1 when ready.
// R17: programming a locked region sets protected_write_error, bit 2.
// R18: status bit 4 shows the security bit.
// R19: status bits 8 and 9 show user nvm bits 0 and 1.
// R20: status bits 16 and up show one lock state per region.
// R21: region count is 16 or 8; unused positions read zero.
// R22: mode enables route idle and error conditions to the interrupt.
// R23: skip_erase low erases the page before programming; high skips.
// R24: accepted command drops idle at once; status read clears errors.
module fcs_flash_command_status_unit #(
    parameter int PAGE_BITS = fcs_pkg::PAGE_FIELD_W,
    parameter int NUM_REGIONS = fcs_pkg::REGIONS_MAX,
    parameter int NUM_NVM = fcs_pkg::NVM_BITS,
    parameter logic [15:0] ERASE_CYC = fcs_pkg::PAGE_ERASE_CYC,
    parameter logic [15:0] PROG_CYC = fcs_pkg::PAGE_PROG_CYC,
    parameter logic [15:0] FULL_CYC = fcs_pkg::FULL_ERASE_CYC,
    parameter logic [15:0] NVM_CYC = fcs_pkg::NVM_WRITE_CYC
)
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_flash_idle,
    output logic o_array_erase,
    output logic o_array_program,
    output logic o_array_full,
    output logic [PAGE_BITS-1:0] o_array_page,
    output logic o_security_on
);

    localparam int RGN_W = $clog2(NUM_REGIONS);
    localparam int NVM_W = (NUM_NVM > 1) ? $clog2(NUM_NVM) : 1;

    ////////////////////////////////////////////////////////////////////////
    // command decode

    fcs_pkg::fcs_state_t state;
    fcs_pkg::fcs_state_t next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [31:0] mode;
    logic [31:0] status_word;
    logic [NUM_REGIONS-1:0] locks;
    logic [NUM_NVM-1:0] user_nvm;
    logic security;
    logic lock_err;
    logic bad_err;
    logic op_full;
    logic op_lock_after;
    logic op_lock_val;
    logic op_nvm_val;
    logic op_sec;
    logic [PAGE_BITS-1:0] op_page;
    logic cmd_wr;
    logic mode_wr;
    logic stat_rd;
    logic key_ok;
    logic code_valid;
    logic is_prog;
    logic idle;
    logic accept;
    logic prot_err;
    logic ea_cancel;
    logic start;
    logic done;
    logic skip_erase;
    logic [3:0] code;
    logic [PAGE_BITS-1:0] pidx;
    logic [RGN_W-1:0] rgn;
    logic [RGN_W-1:0] op_rgn;
    logic [NVM_W-1:0] op_nvm_idx;

    assign cmd_wr = i_clk_en && i_wr && (i_addr == fcs_pkg::OFS_CMD);
    assign mode_wr = i_clk_en && i_wr && (i_addr == fcs_pkg::OFS_MODE);
    assign stat_rd = i_clk_en && i_rd && (i_addr == fcs_pkg::OFS_STAT);
    assign key_ok = i_wdata[fcs_pkg::KEY_HI:fcs_pkg::KEY_LO] == fcs_pkg::CMD_KEY; // R14
    assign code = i_wdata[fcs_pkg::CODE_HI:fcs_pkg::CODE_LO];
    // upper page bits dropped when the array is smaller
    assign pidx = i_wdata[fcs_pkg::PAGE_LO +: PAGE_BITS]; // R12 R13
    assign rgn = pidx[PAGE_BITS-1 -: RGN_W]; // R13
    assign op_rgn = op_page[PAGE_BITS-1 -: RGN_W];
    assign op_nvm_idx = op_page[NVM_W-1:0]; // R13
    assign skip_erase = mode[fcs_pkg::MD_BIT_SKIP_ERASE];
    assign idle = (state == fcs_pkg::ST_IDLE);
    assign done = (cnt == fcs_pkg::CNT_ZERO);

    always_comb
    begin
        case (code)
            fcs_pkg::CMD_NOP,
            fcs_pkg::CMD_WRITE_PAGE,
            fcs_pkg::CMD_SET_LOCK,
            fcs_pkg::CMD_WRITE_PAGE_LOCK,
            fcs_pkg::CMD_UNLOCK_REGION,
            fcs_pkg::CMD_ERASE_ALL,
            fcs_pkg::CMD_SET_USER_NVM_BIT,
            fcs_pkg::CMD_CLEAR_USER_NVM_BIT,
            fcs_pkg::CMD_SET_SECURITY: code_valid = 1'b1;
            default: code_valid = 1'b0; // R11
        endcase
    end

    assign is_prog = (code == fcs_pkg::CMD_WRITE_PAGE) || (code == fcs_pkg::CMD_WRITE_PAGE_LOCK);
    // valid commands while busy are dropped silently; software polls idle first
    assign accept = cmd_wr && key_ok && code_valid && (code != fcs_pkg::CMD_NOP) && idle; // R1 R16
    assign prot_err = accept && is_prog && locks[rgn]; // R17
    assign ea_cancel = accept && (code == fcs_pkg::CMD_ERASE_ALL) && (|locks); // R7
    assign start = accept && !prot_err && !ea_cancel;

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb
    begin
        next_state = state;
        case (state)
            fcs_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    case (code)
                        fcs_pkg::CMD_WRITE_PAGE,
                        fcs_pkg::CMD_WRITE_PAGE_LOCK:
                            next_state = skip_erase ? fcs_pkg::ST_PROG : fcs_pkg::ST_ERASE; // R2 R23
                        fcs_pkg::CMD_SET_LOCK,
                        fcs_pkg::CMD_UNLOCK_REGION: next_state = fcs_pkg::ST_LOCK; // R3 R5
                        fcs_pkg::CMD_ERASE_ALL: next_state = fcs_pkg::ST_ERASE; // R6
                        default: next_state = fcs_pkg::ST_NVM; // R8 R9 R10
                    endcase
                end
            end
            fcs_pkg::ST_ERASE:
            begin
                if (done)
                begin
                    next_state = op_full ? fcs_pkg::ST_IDLE : fcs_pkg::ST_PROG;
                end
            end
            fcs_pkg::ST_PROG:
            begin
                if (done)
                begin
                    next_state = op_lock_after ? fcs_pkg::ST_LOCK : fcs_pkg::ST_IDLE; // R4
                end
            end
            fcs_pkg::ST_LOCK,
            fcs_pkg::ST_NVM:
            begin
                if (done)
                begin
                    next_state = fcs_pkg::ST_IDLE;
                end
            end
            default: next_state = fcs_pkg::ST_IDLE;
        endcase
    end

    // counter preloads one less so a phase lasts exactly its figure
    always_comb
    begin
        next_cnt = done ? fcs_pkg::CNT_ZERO : cnt - fcs_pkg::CNT_ONE;
        if (next_state != state)
        begin
            case (next_state)
                fcs_pkg::ST_ERASE:
                    next_cnt = (idle ? (code == fcs_pkg::CMD_ERASE_ALL) : op_full) ?
                        FULL_CYC - fcs_pkg::CNT_ONE : ERASE_CYC - fcs_pkg::CNT_ONE;
                fcs_pkg::ST_PROG: next_cnt = PROG_CYC - fcs_pkg::CNT_ONE;
                fcs_pkg::ST_LOCK,
                fcs_pkg::ST_NVM: next_cnt = NVM_CYC - fcs_pkg::CNT_ONE;
                default: next_cnt = fcs_pkg::CNT_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            state <= fcs_pkg::ST_IDLE;
            cnt <= fcs_pkg::CNT_ZERO;
        end
        else if (i_clk_en)
        begin
            state <= next_state; // R24
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            op_full <= 1'b0;
            op_lock_after <= 1'b0;
            op_lock_val <= 1'b0;
            op_nvm_val <= 1'b0;
            op_sec <= 1'b0;
            op_page <= '0;
        end
        else if (start)
        begin
            op_full <= (code == fcs_pkg::CMD_ERASE_ALL);
            op_lock_after <= (code == fcs_pkg::CMD_WRITE_PAGE_LOCK) || (code == fcs_pkg::CMD_SET_LOCK); // R4
            op_lock_val <= (code != fcs_pkg::CMD_UNLOCK_REGION);
            op_nvm_val <= (code == fcs_pkg::CMD_SET_USER_NVM_BIT);
            op_sec <= (code == fcs_pkg::CMD_SET_SECURITY); // R10
            op_page <= pidx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nonvolatile state images

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            locks <= '0;
        end
        else if (i_clk_en && (state == fcs_pkg::ST_LOCK) && done)
        begin
            locks[op_rgn] <= op_lock_val; // R3 R4 R5
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            user_nvm <= '0;
            security <= 1'b0;
        end
        else if (i_clk_en && (state == fcs_pkg::ST_NVM) && done)
        begin
            if (op_sec)
            begin
                security <= 1'b1; // R10
            end
            else
            begin
                user_nvm[op_nvm_idx] <= op_nvm_val; // R8 R9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error flags, set wins over the clearing read

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            lock_err <= 1'b0;
        end
        else if (prot_err)
        begin
            lock_err <= 1'b1; // R17
        end
        else if (stat_rd)
        begin
            lock_err <= 1'b0; // R24
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            bad_err <= 1'b0;
        end
        else if (cmd_wr && (!key_ok || !code_valid))
        begin
            bad_err <= 1'b1; // R11 R14 R15
        end
        else if (stat_rd)
        begin
            bad_err <= 1'b0; // R24
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            mode <= fcs_pkg::MODE_RESET;
        end
        else if (mode_wr)
        begin
            mode <= i_wdata & fcs_pkg::MODE_MASK;
        end
    end

    always_comb
    begin
        status_word = '0;
        status_word[fcs_pkg::ST_BIT_IDLE] = idle; // R16
        status_word[fcs_pkg::ST_BIT_LOCK_ERR] = lock_err; // R17
        status_word[fcs_pkg::ST_BIT_BAD_CMD] = bad_err; // R15
        status_word[fcs_pkg::ST_BIT_SECURITY] = security; // R18
        status_word[fcs_pkg::ST_BIT_NVM +: NUM_NVM] = user_nvm; // R19
        // absent regions stay zero in the small build
        status_word[fcs_pkg::ST_BIT_LOCKS +: NUM_REGIONS] = locks; // R20 R21
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_rdata <= '0;
        end
        else if (i_clk_en)
        begin
            if (i_rd && (i_addr == fcs_pkg::OFS_STAT))
            begin
                o_rdata <= status_word;
            end
            else if (i_rd && (i_addr == fcs_pkg::OFS_MODE))
            begin
                o_rdata <= mode;
            end
            else
            begin
                o_rdata <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_irq <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_irq <= (mode[fcs_pkg::MD_BIT_IE_IDLE] && idle) ||
                     (mode[fcs_pkg::MD_BIT_IE_LOCK] && lock_err) ||
                     (mode[fcs_pkg::MD_BIT_IE_BAD] && bad_err); // R22
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_flash_idle <= 1'b1;
            o_array_erase <= 1'b0;
            o_array_program <= 1'b0;
            o_array_full <= 1'b0;
            o_array_page <= '0;
            o_security_on <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_flash_idle <= (next_state == fcs_pkg::ST_IDLE); // R16
            o_array_erase <= (next_state == fcs_pkg::ST_ERASE);
            o_array_program <= (next_state == fcs_pkg::ST_PROG);
            o_array_full <= (next_state == fcs_pkg::ST_ERASE) && (idle ? (code == fcs_pkg::CMD_ERASE_ALL) : op_full);
            o_array_page <= start ? pidx : op_page;
            o_security_on <= security;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    nop_keeps_flag_a: assert property ( // R1
        cmd_wr && key_ok && (code == fcs_pkg::CMD_NOP) && idle |=> (bad_err == $past(bad_err)) && idle)
        else $error("nop changed flag or started");
    bad_key_flag_a: assert property ( // R14
        cmd_wr && !key_ok && idle |=> bad_err && idle)
        else $error("bad key not flagged or started");
    reserved_code_a: assert property ( // R11
        cmd_wr && key_ok && !code_valid |=> bad_err && ($past(idle) == idle || !$past(idle)))
        else $error("reserved code not flagged");
    accept_busy_a: assert property ( // R24
        start |=> !o_flash_idle && !status_word[fcs_pkg::ST_BIT_IDLE])
        else $error("idle not dropped after accept");
    locked_prog_a: assert property ( // R17
        prot_err |=> lock_err && idle && !o_array_program)
        else $error("locked page write not refused");
    erase_cancel_a: assert property ( // R7
        ea_cancel |=> idle ##1 !o_array_erase)
        else $error("erase all not cancelled");
    skip_erase_a: assert property ( // R23
        start && is_prog && skip_erase |=> state == fcs_pkg::ST_PROG)
        else $error("erase not skipped");
    auto_erase_a: assert property ( // R23
        start && is_prog && !skip_erase |=> state == fcs_pkg::ST_ERASE)
        else $error("page not erased first");
    lock_after_a: assert property ( // R4
        i_clk_en && (state == fcs_pkg::ST_PROG) && done && op_lock_after |=> state == fcs_pkg::ST_LOCK)
        else $error("lock did not follow program");
    read_clears_a: assert property ( // R24
        stat_rd && !prot_err && !(cmd_wr) |=> !lock_err && !bad_err)
        else $error("status read did not clear");
    security_set_a: assert property ( // R10
        i_clk_en && (state == fcs_pkg::ST_NVM) && done && op_sec |=> security ##1 (o_security_on || !$past(i_clk_en)))
        else $error("security bit not set");
    bad_irq_a: assert property ( // R22
        i_clk_en && mode[fcs_pkg::MD_BIT_IE_BAD] && bad_err |=> o_irq)
        else $error("enabled error gave no interrupt");

    wpl_seen_c: cover property (start && (code == fcs_pkg::CMD_WRITE_PAGE_LOCK));
    cancel_seen_c: cover property (ea_cancel);
    prot_seen_c: cover property (prot_err);
    nvm_done_c: cover property ((state == fcs_pkg::ST_NVM) && done && i_clk_en);

endmodule : fcs_flash_command_status_unit

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
    ////////////////////////////////////////////////////////////////
    // short op lengths keep the run brief; expectations follow them
    localparam logic [15:0] T_ERASE = 16'h0002;
    localparam logic [15:0] T_PROG = 16'h0003;
    localparam logic [15:0] T_FULL = 16'h0004;
    localparam logic [15:0] T_NVM = 16'h0002;
    localparam logic [3:0] RSVD_CODES [7] = '{4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hc, 4'he};
    logic i_core_clk;
    logic i_reset;
    logic i_clk_en;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic o_irq;
    logic o_flash_idle;
    logic o_array_erase;
    logic o_array_program;
    logic o_array_full;
    logic [9:0] o_array_page;
    logic o_security_on;
    int n_errors;
    int n_compared;
    logic [15:0] m_lock;
    logic [1:0] m_nvm;
    logic m_sec;
    logic [31:0] rv;
    int k;

    fcs_flash_command_status_unit #(
        .ERASE_CYC(T_ERASE),
        .PROG_CYC(T_PROG),
        .FULL_CYC(T_FULL),
        .NVM_CYC(T_NVM)
    ) i_dut (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_clk_en(i_clk_en),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_irq(o_irq),
        .o_flash_idle(o_flash_idle),
        .o_array_erase(o_array_erase),
        .o_array_program(o_array_program),
        .o_array_full(o_array_full),
        .o_array_page(o_array_page),
        .o_security_on(o_security_on)
    );

    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd

    task automatic cmd(input logic [3:0] code, input logic [9:0] page, input logic [7:0] key);
        wr(fcs_pkg::OFS_CMD, {key, 6'h00, page, 4'h0, code});
        #1;
    endtask : cmd

    // bounded wait; a hang counts as a mismatch
    task automatic wait_idle;
        for (k = 0; k < 2000 && o_flash_idle !== 1'b1; k++)
            @(posedge i_core_clk) #1;
        chk("idle wait", 32'h1, {31'h0, o_flash_idle});
    endtask : wait_idle

    function automatic logic [31:0] stat(input logic lerr, input logic bad);
        return {m_lock, 6'h00, m_nvm, 3'h0, m_sec, bad, lerr, 1'b0, 1'b1};
    endfunction : stat

    task automatic rs(input string nm, input logic lerr, input logic bad);
        rd(fcs_pkg::OFS_STAT, rv);
        chk(nm, stat(lerr, bad), rv);
    endtask : rs

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        n_errors++;
        end_sim();
    end

    initial
    begin
        n_errors = 0;
        n_compared = 0;
        m_lock = 16'h0000;
        m_nvm = 2'b00;
        m_sec = 1'b0;
        i_reset = 1'b1;
        i_clk_en = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_reset <= 1'b0;
        rs("status at reset", 1'b0, 1'b0);
        rd(fcs_pkg::OFS_MODE, rv);
        chk("mode at reset", 32'h0, rv);
        rd(8'h6c, rv);
        chk("unmapped read", 32'h0, rv);
        // frozen clock enable ignores the bus
        @(posedge i_core_clk);
        i_clk_en <= 1'b0;
        wr(fcs_pkg::OFS_MODE, 32'h0000_0001);
        i_clk_en <= 1'b1;
        rd(fcs_pkg::OFS_MODE, rv);
        chk("mode frozen", 32'h0, rv);
        // wrong key: nothing starts, error flag set, read clears it
        cmd(fcs_pkg::CMD_SET_SECURITY, 10'h000, 8'ha5);
        chk("idle bad key", 32'h1, {31'h0, o_flash_idle});
        rs("bad key flag", 1'b0, 1'b1);
        rs("flag cleared", 1'b0, 1'b0);
        cmd(fcs_pkg::CMD_NOP, 10'h000, fcs_pkg::CMD_KEY);
        chk("nop idle", 32'h1, {31'h0, o_flash_idle});
        rs("nop status", 1'b0, 1'b0);
        // every reserved code
        foreach (RSVD_CODES[i])
        begin
            cmd(RSVD_CODES[i], 10'h155, fcs_pkg::CMD_KEY);
            chk("reserved idle", 32'h1, {31'h0, o_flash_idle});
            rs("reserved flag", 1'b0, 1'b1);
        end
        // page write with erase first
        cmd(fcs_pkg::CMD_WRITE_PAGE, 10'h155, fcs_pkg::CMD_KEY);
        chk("wp busy", 32'h0, {31'h0, o_flash_idle});
        chk("wp erase", 32'h1, {31'h0, o_array_erase});
        chk("wp page", 32'h155, {22'h0, o_array_page});
        rd(fcs_pkg::OFS_STAT, rv);
        chk("busy status", 32'h0, rv & 32'h1);
        wait_idle();
        rs("wp done", 1'b0, 1'b0);
        // skip_erase goes straight to programming
        wr(fcs_pkg::OFS_MODE, 32'h0000_0080);
        cmd(fcs_pkg::CMD_WRITE_PAGE, 10'h2aa, fcs_pkg::CMD_KEY);
        chk("no erase", 32'h0, {31'h0, o_array_erase});
        chk("prog now", 32'h1, {31'h0, o_array_program});
        wait_idle();
        wr(fcs_pkg::OFS_MODE, 32'h0000_0000);
        // lock region 15 then unlock it by another page of the region
        cmd(fcs_pkg::CMD_SET_LOCK, 10'h3ff, fcs_pkg::CMD_KEY);
        wait_idle();
        m_lock[15] = 1'b1;
        rs("lock 15", 1'b0, 1'b0);
        cmd(fcs_pkg::CMD_UNLOCK_REGION, 10'h3c0, fcs_pkg::CMD_KEY);
        wait_idle();
        m_lock[15] = 1'b0;
        rs("unlock 15", 1'b0, 1'b0);
        // program then lock region 2
        cmd(fcs_pkg::CMD_WRITE_PAGE_LOCK, 10'h080, fcs_pkg::CMD_KEY);
        chk("wpl erase", 32'h1, {31'h0, o_array_erase});
        wait_idle();
        m_lock[2] = 1'b1;
        rs("wpl locked", 1'b0, 1'b0);
        // programming a locked region is refused with an interrupt
        wr(fcs_pkg::OFS_MODE, 32'h0000_0004);
        cmd(fcs_pkg::CMD_WRITE_PAGE, 10'h0bf, fcs_pkg::CMD_KEY);
        chk("locked idle", 32'h1, {31'h0, o_flash_idle});
        repeat (2) @(posedge i_core_clk);
        #1;
        chk("lock irq", 32'h1, {31'h0, o_irq});
        rs("lock error", 1'b1, 1'b0);
        rs("lock err clear", 1'b0, 1'b0);
        repeat (2) @(posedge i_core_clk);
        #1;
        chk("lock irq low", 32'h0, {31'h0, o_irq});
        // full erase cancelled while a region is locked
        cmd(fcs_pkg::CMD_ERASE_ALL, 10'h000, fcs_pkg::CMD_KEY);
        chk("ea cancel", 32'h0, {31'h0, o_array_erase});
        wait_idle();
        rs("ea cancel st", 1'b0, 1'b0);
        cmd(fcs_pkg::CMD_UNLOCK_REGION, 10'h0bf, fcs_pkg::CMD_KEY);
        wait_idle();
        m_lock[2] = 1'b0;
        cmd(fcs_pkg::CMD_ERASE_ALL, 10'h3ff, fcs_pkg::CMD_KEY);
        chk("ea full", 32'h1, {31'h0, o_array_full});
        chk("ea erase", 32'h1, {31'h0, o_array_erase});
        wait_idle();
        // user bits, upper index bits ignored
        cmd(fcs_pkg::CMD_SET_USER_NVM_BIT, 10'h001, fcs_pkg::CMD_KEY);
        wait_idle();
        m_nvm[1] = 1'b1;
        rs("nvm1 set", 1'b0, 1'b0);
        cmd(fcs_pkg::CMD_SET_USER_NVM_BIT, 10'h3fe, fcs_pkg::CMD_KEY);
        wait_idle();
        m_nvm[0] = 1'b1;
        rs("nvm0 set", 1'b0, 1'b0);
        cmd(fcs_pkg::CMD_CLEAR_USER_NVM_BIT, 10'h201, fcs_pkg::CMD_KEY);
        wait_idle();
        m_nvm[1] = 1'b0;
        rs("nvm1 clear", 1'b0, 1'b0);
        // security, bad command and idle interrupts
        cmd(fcs_pkg::CMD_SET_SECURITY, 10'h3ff, fcs_pkg::CMD_KEY);
        wait_idle();
        m_sec = 1'b1;
        rs("security", 1'b0, 1'b0);
        #1;
        chk("security pin", 32'h1, {31'h0, o_security_on});
        wr(fcs_pkg::OFS_MODE, 32'h0000_0008);
        cmd(4'h7, 10'h000, fcs_pkg::CMD_KEY);
        repeat (2) @(posedge i_core_clk);
        #1;
        chk("bad irq", 32'h1, {31'h0, o_irq});
        wr(fcs_pkg::OFS_MODE, 32'h0000_0001);
        rd(fcs_pkg::OFS_MODE, rv);
        chk("mode rb", 32'h1, rv);
        rs("bad flag", 1'b0, 1'b1);
        repeat (2) @(posedge i_core_clk);
        #1;
        chk("idle irq", 32'h1, {31'h0, o_irq});
        end_sim();
    end
endmodule : tb
